// ==== core/rbt_pkg.sv ====
// constants for the registered bus transceiver: widths, register map, fields, resets
// assumes a 32-bit AHB-Lite register bus and byte addresses decoded on the low eight bits
package rbt_pkg;
  localparam int          RBT_DATA_W      = 18;
  localparam int          RBT_PIPE_STAGES = 3;
  localparam int          RBT_LOG_DEPTH   = 4;
  localparam int          RBT_SYNC_CTL_W  = 8;
  localparam int          RBT_ADDR_W      = 8;

  // register byte offsets
  localparam logic [7:0]  RBT_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  RBT_STATUS_OFS  = 8'h04;
  localparam logic [7:0]  RBT_AB_DATA_OFS = 8'h08;
  localparam logic [7:0]  RBT_BA_DATA_OFS = 8'h0C;
  localparam logic [7:0]  RBT_LOG_OFS     = 8'h10;

  // control fields
  localparam int          RBT_CTRL_AB_RUN = 0;
  localparam int          RBT_CTRL_BA_RUN = 1;
  localparam logic [1:0]  RBT_CTRL_RESET  = 2'h3;

  // status fields
  localparam int          RBT_ST_LOG_AVAIL = 0;
  localparam int          RBT_ST_LOG_OVF   = 1;
  localparam int          RBT_ST_SEL       = 2;
  localparam int          RBT_ST_AB_OE     = 3;
  localparam int          RBT_ST_BA_OE     = 4;

  // positions inside the synchronised control vector
  localparam int          RBT_C_OE_AB_N = 0;
  localparam int          RBT_C_OE_BA_N = 1;
  localparam int          RBT_C_CE_AB_N = 2;
  localparam int          RBT_C_CE_BA_N = 3;
  localparam int          RBT_C_CLK_AB  = 4;
  localparam int          RBT_C_CLK1_BA = 5;
  localparam int          RBT_C_CLK2_BA = 6;
  localparam int          RBT_C_SEL     = 7;
  // enables idle high (disabled), clocks and select idle low
  localparam logic [7:0]  RBT_SYNC_CTL_RESET = 8'h0F;

  localparam logic [31:0] RBT_WORD_ZERO = 32'h00000000;
  localparam logic [1:0]  RBT_HRESP_OKAY = 2'h0;
endpackage

// ==== core/rbt_transceiver.sv ====
// registered 18-bit bus transceiver with an AHB-Lite register slave and a capture log
// assumes port pins and the three port clocks are asynchronous to I_REF_CLK and
// much slower than it; the bench resolves the A and B wires from the enables
//
// How it works
// - eighteen bits each way, separate paths
// - own output and clock enable per direction
// - one register from A to B
// - capture on rising edge, enable low only
// - A-to-B register uses only its clock
// - enable high holds output value
// - select picks pipeline or single register
// - select high: second clock loads B
// - select low: three first, one second
// - B-to-A never uses A-to-B clock
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.

// small FIFO with valid and ready on both sides
module rbt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_IDX) ? '0 : AW'(p + 1'b1);
  endfunction

  // honest full and empty from the fill count
  assign o_in_ready  = (count_reg != DEPTH_CNT);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_clk_en && i_in_valid && o_in_ready;
  assign pop         = i_clk_en && i_out_ready && o_out_valid;

  // storage array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= (AW + 1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= (AW + 1)'(count_reg - 1'b1);
      end
    end
  end
endmodule

module rbt_transceiver
  import rbt_pkg::*;
#(
  parameter int DATA_W    = RBT_DATA_W,
  parameter int LOG_DEPTH = RBT_LOG_DEPTH
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RESET,
  input  wire logic              I_CLK_EN,
  // AHB-Lite slave
  input  wire logic              I_HSEL,
  input  wire logic [31:0]       I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic [31:0]       I_HWDATA,
  input  wire logic              I_HREADY,
  output logic                   O_HREADYOUT,
  output logic [1:0]             O_HRESP,
  output logic [31:0]            O_HRDATA,
  // port control pins
  input  wire logic              I_A_TO_B_OUTPUT_ENABLE_N,
  input  wire logic              I_B_TO_A_OUTPUT_ENABLE_N,
  input  wire logic              I_A_TO_B_CLOCK_ENABLE_N,
  input  wire logic              I_B_TO_A_CLOCK_ENABLE_N,
  input  wire logic              I_A_TO_B_CLOCK,
  input  wire logic              I_B_TO_A_FIRST_CLOCK,
  input  wire logic              I_B_TO_A_SECOND_CLOCK,
  input  wire logic              I_PATH_SELECT,
  // two-way data ports
  input  wire logic [DATA_W-1:0] I_A_IN,
  output logic [DATA_W-1:0]      O_A_OUT,
  output logic                   O_A_OE,
  input  wire logic [DATA_W-1:0] I_B_IN,
  output logic [DATA_W-1:0]      O_B_OUT,
  output logic                   O_B_OE,
  // capture log can accept another word
  output logic                   O_LOG_READY
);
  logic [RBT_SYNC_CTL_W-1:0] ctl_s1_reg;
  logic [RBT_SYNC_CTL_W-1:0] ctl_s2_reg;
  logic [RBT_SYNC_CTL_W-1:0] ctl_s3_reg;
  logic [DATA_W-1:0]         a_s1_reg;
  logic [DATA_W-1:0]         a_s2_reg;
  logic [DATA_W-1:0]         b_s1_reg;
  logic [DATA_W-1:0]         b_s2_reg;
  logic [DATA_W-1:0]         ab_reg;
  logic [DATA_W-1:0]         ba_out_reg;
  logic [DATA_W-1:0]         pipe_reg [RBT_PIPE_STAGES];
  logic [1:0]                ctrl_reg;
  logic                      ovf_reg;
  logic [31:0]               rdata_reg;
  logic                      wr_pend_reg;
  logic [7:0]                wr_addr_reg;
  logic                      ab_capture;
  logic                      ba_first_adv;
  logic                      ba_second_load;
  logic                      addr_phase;
  logic                      rd_access;
  logic                      log_pop;
  logic                      log_valid;
  logic                      log_ready;
  logic [DATA_W-1:0]         log_data;
  logic [7:0]                addr_lo;

  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v && !old_v;
  endfunction

  // two-flop synchronisers plus one history flop for edge detection
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctl_s1_reg <= RBT_SYNC_CTL_RESET;
      ctl_s2_reg <= RBT_SYNC_CTL_RESET;
      ctl_s3_reg <= RBT_SYNC_CTL_RESET;
    end else if (I_CLK_EN) begin
      ctl_s1_reg <= {I_PATH_SELECT, I_B_TO_A_SECOND_CLOCK, I_B_TO_A_FIRST_CLOCK, I_A_TO_B_CLOCK,
                     I_B_TO_A_CLOCK_ENABLE_N, I_A_TO_B_CLOCK_ENABLE_N,
                     I_B_TO_A_OUTPUT_ENABLE_N, I_A_TO_B_OUTPUT_ENABLE_N};
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
    end
  end

  // data synchronisers, aligned with the clock samples
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      a_s1_reg <= '0;
      a_s2_reg <= '0;
      b_s1_reg <= '0;
      b_s2_reg <= '0;
    end else if (I_CLK_EN) begin
      a_s1_reg <= I_A_IN;
      a_s2_reg <= a_s1_reg;
      b_s1_reg <= I_B_IN;
      b_s2_reg <= b_s1_reg;
    end
  end

  // per-direction capture strobes, each gated by its own enable
  assign ab_capture     = rise(ctl_s2_reg[RBT_C_CLK_AB], ctl_s3_reg[RBT_C_CLK_AB]) &&
                          !ctl_s2_reg[RBT_C_CE_AB_N] && ctrl_reg[RBT_CTRL_AB_RUN];
  assign ba_first_adv   = rise(ctl_s2_reg[RBT_C_CLK1_BA], ctl_s3_reg[RBT_C_CLK1_BA]) &&
                          !ctl_s2_reg[RBT_C_CE_BA_N] && ctrl_reg[RBT_CTRL_BA_RUN];
  assign ba_second_load = rise(ctl_s2_reg[RBT_C_CLK2_BA], ctl_s3_reg[RBT_C_CLK2_BA]) &&
                          !ctl_s2_reg[RBT_C_CE_BA_N] && ctrl_reg[RBT_CTRL_BA_RUN];

  // A-to-B single register, held while not captured
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ab_reg <= '0;
    end else if (I_CLK_EN && ab_capture) begin
      ab_reg <= a_s2_reg;
    end
  end

  // B-to-A three-stage front on the first clock
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      for (int i = 0; i < RBT_PIPE_STAGES; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (I_CLK_EN && ba_first_adv) begin
      pipe_reg[0] <= b_s2_reg;
      for (int i = 1; i < RBT_PIPE_STAGES; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // B-to-A output stage on the second clock, select picks the source
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ba_out_reg <= '0;
    end else if (I_CLK_EN && ba_second_load) begin
      if (ctl_s2_reg[RBT_C_SEL]) begin
        ba_out_reg <= b_s2_reg;
      end else begin
        ba_out_reg <= pipe_reg[RBT_PIPE_STAGES-1];
      end
    end
  end

  // port drivers; enables high float the port, registers keep running
  assign O_B_OUT = ab_reg;
  assign O_A_OUT = ba_out_reg;
  assign O_B_OE  = !ctl_s2_reg[RBT_C_OE_AB_N];
  assign O_A_OE  = !ctl_s2_reg[RBT_C_OE_BA_N];

  // log of A-to-B captures; a full log drops the word and flags it
  rbt_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .i_clk       (I_REF_CLK),
    .i_reset     (I_RESET),
    .i_clk_en    (I_CLK_EN),
    .i_in_valid  (ab_capture),
    .o_in_ready  (log_ready),
    .i_in_data   (a_s2_reg),
    .o_out_valid (log_valid),
    .i_out_ready (log_pop),
    .o_out_data  (log_data)
  );
  assign O_LOG_READY = log_ready;

  // bus decode; zero wait states, frozen with the clock enable
  assign addr_lo     = I_HADDR[RBT_ADDR_W-1:0];
  assign addr_phase  = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign rd_access   = addr_phase && !I_HWRITE;
  assign log_pop     = rd_access && (addr_lo == RBT_LOG_OFS);
  assign O_HREADYOUT = I_CLK_EN;
  assign O_HRESP     = RBT_HRESP_OKAY;
  assign O_HRDATA    = rdata_reg;

  // write address latch for the data phase
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (I_CLK_EN) begin
      wr_pend_reg <= addr_phase && I_HWRITE;
      wr_addr_reg <= addr_lo;
    end
  end

  // control register
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_reg <= RBT_CTRL_RESET;
    end else if (I_CLK_EN && wr_pend_reg && wr_addr_reg == RBT_CTRL_OFS) begin
      ctrl_reg <= I_HWDATA[1:0];
    end
  end

  // sticky overflow, write one to clear, a new drop wins
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ovf_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      if (ab_capture && !log_ready) begin
        ovf_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == RBT_STATUS_OFS && I_HWDATA[RBT_ST_LOG_OVF]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // read data registered in the address phase
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rdata_reg <= RBT_WORD_ZERO;
    end else if (I_CLK_EN && rd_access) begin
      rdata_reg <= RBT_WORD_ZERO;
      case (addr_lo)
        RBT_CTRL_OFS: begin
          rdata_reg[1:0] <= ctrl_reg;
        end
        RBT_STATUS_OFS: begin
          rdata_reg[RBT_ST_LOG_AVAIL] <= log_valid;
          rdata_reg[RBT_ST_LOG_OVF]   <= ovf_reg;
          rdata_reg[RBT_ST_SEL]       <= ctl_s2_reg[RBT_C_SEL];
          rdata_reg[RBT_ST_AB_OE]     <= O_B_OE;
          rdata_reg[RBT_ST_BA_OE]     <= O_A_OE;
        end
        RBT_AB_DATA_OFS: begin
          rdata_reg[DATA_W-1:0] <= ab_reg;
        end
        RBT_BA_DATA_OFS: begin
          rdata_reg[DATA_W-1:0] <= ba_out_reg;
        end
        RBT_LOG_OFS: begin
          if (log_valid) begin
            rdata_reg[DATA_W-1:0] <= log_data;
          end
        end
        default: begin
          rdata_reg <= RBT_WORD_ZERO;
        end
      endcase
    end
  end
endmodule

// ==== testbench/rbt_transceiver_monitor.sv ====
// checker on the port side: output enables, and when port outputs may move
// assumes pins stay steady a few reference cycles around each port clock rise
module rbt_transceiver_monitor
  import rbt_pkg::*;
#(
  parameter int DATA_W    = RBT_DATA_W,
  parameter int LOG_DEPTH = RBT_LOG_DEPTH
) (
  input wire logic              I_REF_CLK,
  input wire logic              I_RESET,
  input wire logic              I_A_TO_B_OUTPUT_ENABLE_N,
  input wire logic              I_B_TO_A_OUTPUT_ENABLE_N,
  input wire logic              I_A_TO_B_CLOCK_ENABLE_N,
  input wire logic              I_B_TO_A_CLOCK_ENABLE_N,
  input wire logic              I_A_TO_B_CLOCK,
  input wire logic              I_B_TO_A_SECOND_CLOCK,
  input wire logic [DATA_W-1:0] O_A_OUT,
  input wire logic              O_A_OE,
  input wire logic [DATA_W-1:0] O_B_OUT,
  input wire logic              O_B_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ab_d, ba2_d;
  logic [7:0] ab_rise, ba2_rise, ce_ab, ce_ba;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // last eight samples of clock rises and enable levels
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ab_d     <= 1'h0;
      ba2_d    <= 1'h0;
      ab_rise  <= 8'h00;
      ba2_rise <= 8'h00;
      ce_ab    <= 8'hFF;
      ce_ba    <= 8'hFF;
    end else begin
      ab_d     <= I_A_TO_B_CLOCK;
      ba2_d    <= I_B_TO_A_SECOND_CLOCK;
      ab_rise  <= {ab_rise[6:0], I_A_TO_B_CLOCK & ~ab_d};
      ba2_rise <= {ba2_rise[6:0], I_B_TO_A_SECOND_CLOCK & ~ba2_d};
      ce_ab    <= {ce_ab[6:0], I_A_TO_B_CLOCK_ENABLE_N};
      ce_ba    <= {ce_ba[6:0], I_B_TO_A_CLOCK_ENABLE_N};
    end
  end
  AST_AB_NEEDS_CLK: assert property ($changed(O_B_OUT) |-> |ab_rise)
    else $error("B output moved without an A-to-B clock rise");
  AST_AB_NEEDS_CE: assert property ($changed(O_B_OUT) |-> !(&ce_ab))
    else $error("B output moved while its clock enable was high");
  AST_BA_NEEDS_CLK2: assert property ($changed(O_A_OUT) |-> |ba2_rise)
    else $error("A output moved without a second B-to-A clock rise");
  AST_BA_HOLD_CE: assert property ((&ce_ba) |-> $stable(O_A_OUT))
    else $error("A output moved while its clock enable was high");
  AST_B_OE_OFF: assert property (I_A_TO_B_OUTPUT_ENABLE_N [*5] |-> !O_B_OE)
    else $error("B port driven with its output enable high");
  AST_B_OE_ON: assert property ((!I_A_TO_B_OUTPUT_ENABLE_N) [*5] |-> O_B_OE)
    else $error("B port not driven with its output enable low");
  AST_A_OE_OFF: assert property (I_B_TO_A_OUTPUT_ENABLE_N [*5] |-> !O_A_OE)
    else $error("A port driven with its output enable high");
  AST_A_OE_ON: assert property ((!I_B_TO_A_OUTPUT_ENABLE_N) [*5] |-> O_A_OE)
    else $error("A port not driven with its output enable low");
  // main scenarios reached
  COV_B_LOAD: cover property ($changed(O_B_OUT));
  COV_A_LOAD: cover property ($changed(O_A_OUT));
  COV_B_DRIVE: cover property ($rose(O_B_OE));
endmodule
bind rbt_transceiver rbt_transceiver_monitor #(.DATA_W(DATA_W), .LOG_DEPTH(LOG_DEPTH)) rbt_transceiver_monitor_inst (
  .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_A_TO_B_OUTPUT_ENABLE_N(I_A_TO_B_OUTPUT_ENABLE_N),
  .I_B_TO_A_OUTPUT_ENABLE_N(I_B_TO_A_OUTPUT_ENABLE_N), .I_A_TO_B_CLOCK_ENABLE_N(I_A_TO_B_CLOCK_ENABLE_N),
  .I_B_TO_A_CLOCK_ENABLE_N(I_B_TO_A_CLOCK_ENABLE_N), .I_A_TO_B_CLOCK(I_A_TO_B_CLOCK),
  .I_B_TO_A_SECOND_CLOCK(I_B_TO_A_SECOND_CLOCK), .O_A_OUT(O_A_OUT), .O_A_OE(O_A_OE), .O_B_OUT(O_B_OUT),
  .O_B_OE(O_B_OE));

// ==== testbench/rbt_bus_model.sv ====
// far side: other devices on the A and B buses, resolving each wire
// assumes the bench chooses what the far side drives and when
module rbt_bus_model
  import rbt_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic [RBT_DATA_W-1:0] i_a_dut,
  input  wire logic                  i_a_dut_oe,
  input  wire logic [RBT_DATA_W-1:0] i_b_dut,
  input  wire logic                  i_b_dut_oe,
  input  wire logic [RBT_DATA_W-1:0] i_a_far,
  input  wire logic [RBT_DATA_W-1:0] i_b_far,
  input  wire logic [1:0]            i_far_en,
  output logic [RBT_DATA_W-1:0]      o_a_wire,
  output logic [RBT_DATA_W-1:0]      o_b_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RBT_DATA_W-1:0] a_last = '0;
  logic [RBT_DATA_W-1:0] b_last = '0;
  // device first, then far side; a floating wire flips every cycle
  always_comb begin
    o_a_wire = i_a_dut_oe ? i_a_dut : (i_far_en[0] ? i_a_far : ~a_last);
    o_b_wire = i_b_dut_oe ? i_b_dut : (i_far_en[1] ? i_b_far : ~b_last);
  end
  // last level of each wire
  always_ff @(posedge i_clk) begin
    a_last <= o_a_wire;
    b_last <= o_b_wire;
  end
endmodule

// ==== testbench/rbt_transceiver_tb.sv ====
// self-checking bench: register bus, both port paths and the capture log
// assumes one 50 MHz reference clock; port clocks are slow pulses made here
module rbt_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rbt_pkg::*;
  logic                  clk, rst, clk_en, hsel, hwrite, sel, hreadyout, a_oe, b_oe, log_ready;
  logic [1:0]            htrans, hresp, far_en;
  logic [2:0]            pclk;
  logic [7:0]            en_n;
  logic [31:0]           haddr, hwdata, hrdata;
  logic [RBT_DATA_W-1:0] a_far, b_far, a_out, b_out, a_wire, b_wire;
  int                    n_errors = 0;
  int                    n_compared = 0;
  // reference clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  rbt_transceiver rbt_transceiver_inst (
    .I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(clk_en), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout),
    .O_HRESP(hresp), .O_HRDATA(hrdata), .I_A_TO_B_OUTPUT_ENABLE_N(en_n[RBT_C_OE_AB_N]),
    .I_B_TO_A_OUTPUT_ENABLE_N(en_n[RBT_C_OE_BA_N]), .I_A_TO_B_CLOCK_ENABLE_N(en_n[RBT_C_CE_AB_N]),
    .I_B_TO_A_CLOCK_ENABLE_N(en_n[RBT_C_CE_BA_N]), .I_A_TO_B_CLOCK(pclk[0]), .I_B_TO_A_FIRST_CLOCK(pclk[1]),
    .I_B_TO_A_SECOND_CLOCK(pclk[2]), .I_PATH_SELECT(sel), .I_A_IN(a_wire), .O_A_OUT(a_out), .O_A_OE(a_oe),
    .I_B_IN(b_wire), .O_B_OUT(b_out), .O_B_OE(b_oe), .O_LOG_READY(log_ready));
  rbt_bus_model rbt_bus_model_inst (
    .i_clk(clk), .i_a_dut(a_out), .i_a_dut_oe(a_oe), .i_b_dut(b_out), .i_b_dut_oe(b_oe), .i_a_far(a_far),
    .i_b_far(b_far), .i_far_en(far_en), .o_a_wire(a_wire), .o_b_wire(b_wire));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single AHB-Lite transfer; a read is compared with exp
  task automatic bus(input logic wr_en, input logic [7:0] ofs, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, ofs};
    hwrite <= wr_en;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    if (!wr_en) check("register read", hrdata, exp);
    check("bus response", hresp, 32'(RBT_HRESP_OKAY));
  endtask
  // one slow pulse on a port clock, data steady around it
  task automatic pulse(input int i);
    repeat (3) @(posedge clk);
    pclk[i] <= 1'h1;
    repeat (4) @(posedge clk);
    pclk[i] <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  // capture log: run bit gate, fill past full, drain in order, clear overflow
  task automatic t_log;
    bus(1'h1, RBT_CTRL_OFS, 32'h0, 32'h0);
    en_n[RBT_C_CE_AB_N] <= 1'h0;
    far_en <= 2'h1;
    a_far <= 18'h0ABCD;
    pulse(0);
    check("b out", b_out, 32'h0);
    bus(1'h1, RBT_CTRL_OFS, {30'h0, RBT_CTRL_RESET}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      a_far <= 18'h00100 + 18'(i);
      pulse(0);
    end
    check("log ready", log_ready, 32'h0);
    bus(1'h0, RBT_STATUS_OFS, 32'h0, 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, RBT_LOG_OFS, 32'h0, 32'h100 + i);
    end
    bus(1'h0, RBT_LOG_OFS, 32'h0, 32'h0);
    bus(1'h1, RBT_STATUS_OFS, 32'h2, 32'h0);
    bus(1'h0, RBT_STATUS_OFS, 32'h0, 32'h0);
    bus(1'h0, 8'h14, 32'h0, 32'h0);
    $display("t_log done");
  endtask
  // A to B: one register, own clock, hold on enable high, float on output enable high
  task automatic t_ab;
    en_n[RBT_C_OE_AB_N] <= 1'h0;
    a_far <= 18'h2A5C3;
    pulse(0);
    check("b wire", b_wire, 32'h2A5C3);
    a_far <= 18'h15A3C;
    pulse(1);
    pulse(2);
    check("b out", b_out, 32'h2A5C3);
    // block clock enable low: a port clock rise while I_CLK_EN is low is ignored
    clk_en <= 1'h0;
    pulse(0);
    check("bus ready", hreadyout, 32'h0);
    clk_en <= 1'h1;
    check("b out", b_out, 32'h2A5C3);
    en_n[RBT_C_CE_AB_N] <= 1'h1;
    pulse(0);
    check("b out", b_out, 32'h2A5C3);
    en_n[RBT_C_CE_AB_N] <= 1'h0;
    en_n[RBT_C_OE_AB_N] <= 1'h1;
    pulse(0);
    check("b drive", b_oe, 32'h0);
    bus(1'h0, RBT_AB_DATA_OFS, 32'h0, 32'h15A3C);
    $display("t_ab done");
  endtask
  // B to A: single register path, then the pipeline
  task automatic t_ba;
    en_n[RBT_C_OE_BA_N] <= 1'h0;
    en_n[RBT_C_CE_BA_N] <= 1'h0;
    far_en <= 2'h2;
    sel <= 1'h1;
    b_far <= 18'h3C0F1;
    pulse(1);
    pulse(0);
    check("a out", a_out, 32'h0);
    pulse(2);
    check("a wire", a_wire, 32'h3C0F1);
    sel <= 1'h0;
    for (int i = 1; i < 4; i++) begin
      b_far <= 18'h11111 * 18'(i);
      pulse(1);
    end
    check("a out", a_out, 32'h3C0F1);
    pulse(2);
    check("a out", a_out, 32'h11111);
    pulse(1);
    pulse(2);
    check("a out", a_out, 32'h22222);
    en_n[RBT_C_CE_BA_N] <= 1'h1;
    pulse(1);
    pulse(2);
    bus(1'h0, RBT_BA_DATA_OFS, 32'h0, 32'h22222);
    $display("t_ba done");
  endtask
  // counts, verdict, end of run
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles expected
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize;
  end
  // reset with both output enables held high, then the tests
  initial begin
    rst = 1'h1;
    clk_en = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    en_n = 8'hFF;
    sel = 1'h0;
    pclk = 3'h0;
    far_en = 2'h0;
    a_far = 18'h0;
    b_far = 18'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_log;
    t_ab;
    t_ba;
    summarize;
  end
endmodule
